// ==== design/clk_fanout_regs.svh ====
`ifndef CLK_FANOUT_REGS_SVH
`define CLK_FANOUT_REGS_SVH

// Register offsets on the local register port (byte addresses)
`define OFS_EN0 8'h00
`define OFS_EN1 8'h04
`define OFS_EN2 8'h08
`define OFS_CTRL 8'h0C
`define OFS_STATUS 8'h10
`define OFS_COUNT 8'h14

// Two-wire device address, 11010010
`define DEV_ADDR 8'hD2

// Implemented enable bits of the three data bytes
`define EN0_MASK 8'hCF
`define EN1_MASK 8'hF3
`define EN2_MASK 8'h40

// Power-up value: every implemented enable set, reserved bits zero
`define EN0_RST 8'hCF
`define EN1_RST 8'hF3
`define EN2_RST 8'h40
`define CTRL_RST 1'h1

// Enable fields inside the data bytes
`define EN0_LOW 3:0
`define EN0_HIGH 7:6
`define EN1_LOW 1:0
`define EN1_HIGH 7:4
`define EN2_BIT 6

// Byte positions inside one write, counted from zero
`define POS_ADDR 4'h0
`define POS_DATA0 4'h3
`define POS_DATA1 4'h4
`define POS_DATA2 4'h5
`define POS_LAST 4'h9

// Bit counting inside one byte
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7

// Status register fields
`define ST_BUSY_BIT 0
`define ST_ADDR_OK_BIT 1
`define ST_POS_FIELD 7:4

`endif

// ==== design/clk_fanout_pkg.sv ====
package clk_fanout_pkg;

    // Byte framing state of the two-wire receiver
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BITS = 2'b01,
        ST_ACK_WAIT = 2'b10,
        ST_ACK_SLOT = 2'b11
    } link_state_t;

    typedef logic [7:0] byte_t;
    typedef logic [31:0] word_t;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/10ps

// Two-stage synchroniser for a group of unrelated levels
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ==== design/clk_fanout_serial_config.sv ====
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "clk_fanout_regs.svh"
//
// Contract
// R1: A configuration write is ten bytes of eight bits after start.
// R2: First byte is the address; only 11010010 selects this device.
// R3: Wrong address leaves every configuration register untouched.
// R4: Second byte, the command code, is ignored.
// R5: Third byte, the byte count, is ignored.
// R6: Master still sends both ignored bytes to keep data aligned.
// R7: Bytes four to six load the three output enable registers.
// R8: Bytes seven to ten are acknowledged and have no effect.
// R9: Each enabled output carries a buffered copy of the reference.
// R10: Outputs are non-inverting copies of the reference clock.
// R11: Data byte bits map to outputs; one runs, zero holds low.
// R12: After power-up every output enable bit is set.
// R13: Device acknowledges each byte and never returns data.
// R14: Master sends each byte most significant bit first.
// R15: Start restarts byte count; stop ends; stored bytes stay.
module clk_fanout_serial_config
    import clk_fanout_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SERIAL_CLOCK_LINE,
    input wire logic SERIAL_DATA_LINE_IN,
    output logic SERIAL_DATA_LINE_OUT,
    output logic SERIAL_DATA_LINE_OE,
    input wire logic REF_CLK_IN,
    output logic [12:0] GATED_CLOCK_OUTPUTS,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);

    // Map the three enable bytes onto the thirteen outputs
    function automatic logic [12:0] map_enables(
        input byte_t en0,
        input byte_t en1,
        input byte_t en2
    );
        map_enables = {en2[`EN2_BIT], en1[`EN1_HIGH], en1[`EN1_LOW],
                       en0[`EN0_HIGH], en0[`EN0_LOW]};
    endfunction

    // Pad a byte into a bus word, upper bits read as zero
    function automatic word_t widen(input byte_t b);
        widen = {24'h000000, b};
    endfunction

    // Link domain
    byte_t shift_ff;

    // System domain: synchronised pins and their delayed copies
    logic [2:0] pins_sync;
    logic scl_s, sda_s, ref_s;
    logic scl_d_ff, sda_d_ff;

    // Receiver state
    link_state_t state_ff;
    logic [2:0] bit_cnt_ff;
    logic [3:0] pos_ff;
    logic addr_ok_ff;
    logic ack_me_ff;
    logic got_data_ff;

    // Configuration and bookkeeping
    byte_t en0_ff, en1_ff, en2_ff;
    logic ctrl_ff;
    byte_t count_ff;

    // Output flops
    logic sda_oe_ff, sda_out_ff;
    logic [12:0] gated_ff;
    word_t rdata_ff;

    // Decoded events
    logic scl_rise, scl_fall, start_seen, stop_seen, byte_done;
    byte_t rx_byte;
    logic addr_match;
    logic store_ok;
    logic nxt_ack_me;
    word_t nxt_rdata;

    // Link clock shifts bits in low; bit 7 ends on top
    // R14: MSB first shift
    always_ff @(posedge SERIAL_CLOCK_LINE) begin
        shift_ff <= {shift_ff[6:0], SERIAL_DATA_LINE_IN};
    end

    // Clock, data and reference pins cross into the system clock
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .async_in({REF_CLK_IN, SERIAL_DATA_LINE_IN, SERIAL_CLOCK_LINE}),
        .sync_out(pins_sync)
    );

    assign scl_s = pins_sync[0];
    assign sda_s = pins_sync[1];
    assign ref_s = pins_sync[2];

    // Delayed copies for edge detection; idle bus reads high
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // Edges of the clock line and bus conditions.
    // Both lines share the same sync latency, so a data change
    // made while the clock is low never looks like start or stop.
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    // R15: start and stop
    assign start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_seen = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Eighth rising edge; the link shift register moved at the real
    // edge and holds until the next one, so it is safe to read here.
    assign byte_done = scl_rise && (state_ff == ST_BITS) &&
                       (bit_cnt_ff == `BIT_LAST);
    assign rx_byte = shift_ff;

    // R2: address compare
    assign addr_match = (rx_byte == `DEV_ADDR);

    // Acknowledge decision for the byte just completed
    always_comb begin
        nxt_ack_me = 1'b0;
        if (pos_ff == `POS_ADDR) begin
            nxt_ack_me = addr_match;
        end else if (addr_ok_ff && (pos_ff <= `POS_LAST)) begin
            // R8: trailing bytes acked
            nxt_ack_me = 1'b1;
        end
    end

    // Data bytes land only when selected and writes are allowed
    // R3: mismatch blocks stores
    // R4: command code dropped
    // R5: byte count dropped
    assign store_ok = byte_done && addr_ok_ff && ctrl_ff;

    // Byte framing state machine
    // R1: ten byte frame
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_ff <= ST_IDLE;
        end else if (start_seen) begin
            state_ff <= ST_BITS;
        end else if (stop_seen) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: state_ff <= ST_IDLE;
                ST_BITS: begin
                    if (byte_done) begin
                        state_ff <= ST_ACK_WAIT;
                    end
                end
                ST_ACK_WAIT: begin
                    if (scl_fall) begin
                        state_ff <= ST_ACK_SLOT;
                    end
                end
                ST_ACK_SLOT: begin
                    // Unselected or overlong frames idle until start
                    if (scl_fall) begin
                        state_ff <= (ack_me_ff && (pos_ff != `POS_LAST)) ?
                                    ST_BITS : ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Bit counter within a byte
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || start_seen) begin
            bit_cnt_ff <= `BIT_FIRST;
        end else if (scl_rise && (state_ff == ST_BITS)) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    // Byte position; restarted by every start, repeated or not
    // R15: start resets position
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || start_seen) begin
            pos_ff <= `POS_ADDR;
        end else if (scl_fall && (state_ff == ST_ACK_SLOT) &&
                     (pos_ff != `POS_LAST)) begin
            pos_ff <= pos_ff + 4'h1;
        end
    end

    // Address match is remembered for the rest of the frame
    // R2: select on match
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || start_seen || stop_seen) begin
            addr_ok_ff <= 1'b0;
        end else if (byte_done && (pos_ff == `POS_ADDR)) begin
            addr_ok_ff <= addr_match;
        end
    end

    // Acknowledge wanted for the current byte; the tenth byte is
    // the last one acked, anything later is left unanswered.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || start_seen) begin
            ack_me_ff <= 1'b0;
        end else if (byte_done) begin
            ack_me_ff <= nxt_ack_me;
        end else if (scl_fall && (state_ff == ST_ACK_SLOT) &&
                     (pos_ff == `POS_LAST)) begin
            ack_me_ff <= 1'b0;
        end
    end

    // Data line driver: pull low through the whole ack bit time.
    // The driver only ever pulls low; no register data goes back.
    // R13: acknowledge only
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || start_seen || stop_seen) begin
            sda_oe_ff <= 1'b0;
        end else if (scl_fall && (state_ff == ST_ACK_WAIT)) begin
            sda_oe_ff <= ack_me_ff;
        end else if (scl_fall && (state_ff == ST_ACK_SLOT)) begin
            sda_oe_ff <= 1'b0;
        end
    end

    // Open-drain level is always low when enabled
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sda_out_ff <= 1'b0;
        end else begin
            sda_out_ff <= 1'b0;
        end
    end

    // Enable byte 0. A serial store wins over a register write in
    // the same cycle, since the serial byte cannot be repeated.
    // R12: all enabled at reset
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            en0_ff <= `EN0_RST;
        end else if (store_ok && (pos_ff == `POS_DATA0)) begin
            // R7: first data byte
            en0_ff <= rx_byte & `EN0_MASK;
        end else if (REG_WR && (REG_ADDR == `OFS_EN0)) begin
            en0_ff <= REG_WDATA[7:0] & `EN0_MASK;
        end
    end

    // Enable byte 1
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            en1_ff <= `EN1_RST;
        end else if (store_ok && (pos_ff == `POS_DATA1)) begin
            // R7: second data byte
            en1_ff <= rx_byte & `EN1_MASK;
        end else if (REG_WR && (REG_ADDR == `OFS_EN1)) begin
            en1_ff <= REG_WDATA[7:0] & `EN1_MASK;
        end
    end

    // Enable byte 2; only one implemented bit
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            en2_ff <= `EN2_RST;
        end else if (store_ok && (pos_ff == `POS_DATA2)) begin
            // R7: third data byte
            en2_ff <= rx_byte & `EN2_MASK;
        end else if (REG_WR && (REG_ADDR == `OFS_EN2)) begin
            en2_ff <= REG_WDATA[7:0] & `EN2_MASK;
        end
    end

    // Serial write permission; bytes are still acked when clear
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_ff <= `CTRL_RST;
        end else if (REG_WR && (REG_ADDR == `OFS_CTRL)) begin
            ctrl_ff <= REG_WDATA[0];
        end
    end

    // Frame stored at least one data byte
    // R15: early stop keeps bytes
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || start_seen || stop_seen) begin
            got_data_ff <= 1'b0;
        end else if (store_ok && (pos_ff >= `POS_DATA0) &&
                     (pos_ff <= `POS_DATA2)) begin
            got_data_ff <= 1'b1;
        end
    end

    // Count of frames that stored at least one enable data byte; wraps at 255.
    // The stop ends the frame, so counting here needs no link clock.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            count_ff <= 8'h00;
        end else if (stop_seen && got_data_ff) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (REG_ADDR)
            `OFS_EN0: nxt_rdata = widen(en0_ff);
            `OFS_EN1: nxt_rdata = widen(en1_ff);
            `OFS_EN2: nxt_rdata = widen(en2_ff);
            `OFS_CTRL: nxt_rdata = {31'h00000000, ctrl_ff};
            `OFS_STATUS: begin
                nxt_rdata[`ST_BUSY_BIT] = (state_ff != ST_IDLE);
                nxt_rdata[`ST_ADDR_OK_BIT] = addr_ok_ff;
                nxt_rdata[`ST_POS_FIELD] = pos_ff;
            end
            `OFS_COUNT: nxt_rdata = widen(count_ff);
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || !REG_RD) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs copy the synchronised reference, gated per enable.
    // Retiming costs three system cycles of delay and limits the
    // reference to well under half the system clock rate.
    // R9: buffered copy
    // R10: same polarity
    // R11: one runs, zero low
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            gated_ff <= 13'h0000;
        end else begin
            gated_ff <= {13{ref_s}} & map_enables(en0_ff, en1_ff, en2_ff);
        end
    end

    assign SERIAL_DATA_LINE_OUT = sda_out_ff;
    assign SERIAL_DATA_LINE_OE = sda_oe_ff;
    assign GATED_CLOCK_OUTPUTS = gated_ff;
    assign REG_RDATA = rdata_ff;

endmodule

// ==== verification/clk_fanout_sva.sv ====
`timescale 1ns/10ps
`include "clk_fanout_regs.svh"
// Pin-level watch on the fan-out block, system clock domain only
module clk_fanout_sva (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SERIAL_CLOCK_LINE,
    input wire logic SERIAL_DATA_LINE_OUT,
    input wire logic SERIAL_DATA_LINE_OE,
    input wire logic REF_CLK_IN,
    input wire logic [12:0] GATED_CLOCK_OUTPUTS,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    // Outputs only run while the retimed reference is high
    AST_OUT_NONINV: assert property (
        |GATED_CLOCK_OUTPUTS |-> $past(REF_CLK_IN, 3))
        else $error("output high while reference was low");
    // Fresh reset with a steady high reference lights all thirteen
    AST_RESET_ALL_ON: assert property (
        $rose(RST_N) ##0 REF_CLK_IN [*6] |-> GATED_CLOCK_OUTPUTS == 13'h1FFF)
        else $error("outputs not all running after reset");
    AST_RDATA_IDLE: assert property (
        !$past(REG_RD) |-> REG_RDATA == 32'h00000000)
        else $error("read data outside its cycle");
    // Open-drain: the device may only pull the data wire low
    AST_OE_PULLS_LOW: assert property (
        SERIAL_DATA_LINE_OE |-> !SERIAL_DATA_LINE_OUT)
        else $error("data wire driven high");
    AST_OE_RISE_SCL_LOW: assert property (
        $rose(SERIAL_DATA_LINE_OE) |-> !SERIAL_CLOCK_LINE)
        else $error("acknowledge started while clock high");
    AST_OE_FALL_SCL_LOW: assert property (
        $fell(SERIAL_DATA_LINE_OE) |-> !SERIAL_CLOCK_LINE)
        else $error("acknowledge dropped while clock high");
    // Acknowledge spans the ninth clock, then lets go
    AST_ACK_LENGTH: assert property (
        $rose(SERIAL_DATA_LINE_OE) |->
            SERIAL_DATA_LINE_OE [*4] ##[1:16] !SERIAL_DATA_LINE_OE)
        else $error("acknowledge length wrong");
    // Reserved enable bits always read back as zero
    AST_EN0_RSVD: assert property (
        REG_RD && REG_ADDR == `OFS_EN0 |=>
            (REG_RDATA & ~{24'h000000, `EN0_MASK}) == 32'h00000000)
        else $error("reserved bits set in enable byte 0");
    AST_EN1_RSVD: assert property (
        REG_RD && REG_ADDR == `OFS_EN1 |=>
            (REG_RDATA & ~{24'h000000, `EN1_MASK}) == 32'h00000000)
        else $error("reserved bits set in enable byte 1");
    AST_EN2_RSVD: assert property (
        REG_RD && REG_ADDR == `OFS_EN2 |=>
            (REG_RDATA & ~{24'h000000, `EN2_MASK}) == 32'h00000000)
        else $error("reserved bits set in enable byte 2");

    COV_ACK: cover property ($rose(SERIAL_DATA_LINE_OE));
    COV_ALL_ON: cover property (GATED_CLOCK_OUTPUTS == 13'h1FFF);
    COV_SOME_OFF: cover property (REF_CLK_IN && $past(REF_CLK_IN, 3)
        && GATED_CLOCK_OUTPUTS != 13'h1FFF);
endmodule

bind clk_fanout_serial_config clk_fanout_sva u_sva (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .SERIAL_CLOCK_LINE(SERIAL_CLOCK_LINE),
    .SERIAL_DATA_LINE_OUT(SERIAL_DATA_LINE_OUT),
    .SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE),
    .REF_CLK_IN(REF_CLK_IN),
    .GATED_CLOCK_OUTPUTS(GATED_CLOCK_OUTPUTS),
    .REG_ADDR(REG_ADDR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA)
);

// ==== verification/serial_master_model.sv ====
`timescale 1ns/10ps
// Behavioural two-wire bus master, 80 ns clock, idle between frames
module serial_master_model (
    output logic scl,
    output logic pull,
    input wire logic sda
);
    // Idle bus: clock high, data left to the pull-up
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic put_bit(input logic b);
        pull = ~b;
        #20 scl = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask

    // Ninth clock: release data, sample the answer mid-high
    task automatic get_ack(output logic a);
        pull = 1'b0;
        #20 scl = 1'b1;
        #20 a = ~sda;
        #20 scl = 1'b0;
        #20;
    endtask

    task automatic frame(input logic [79:0] b, input int n,
                         output logic [9:0] acks);
        logic a;
        acks = 10'h000;
        #3;
        // Start: data falls while clock high
        pull = 1'b1;
        #20 scl = 1'b0;
        #20;
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) put_bit(b[72 - 8 * i + j]);
            get_ack(a);
            acks[i] = a;
            // Keeps sending past a missed address so stores get tested
        end
        // Stop: data rises while clock high
        pull = 1'b1;
        #20 scl = 1'b1;
        #20 pull = 1'b0;
        #40;
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`include "clk_fanout_regs.svh"
module tb
    import clk_fanout_pkg::*;
();
    logic sys_clk, rst_n, ref_clk, reg_wr, reg_rd, sda_out, sda_oe, scl;
    logic m_pull;
    wire logic sda;
    logic [7:0] reg_addr;
    word_t reg_wdata, reg_rdata, d;
    logic [12:0] gated;
    logic [79:0] b;
    logic [95:0] r;
    logic [9:0] acks;
    byte_t e0, e1, e2;
    int n_errors, n_checks, seed;

    // Wired-AND data line with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~m_pull;

    clk_fanout_serial_config DUT (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .SERIAL_CLOCK_LINE(scl), .SERIAL_DATA_LINE_IN(sda),
        .SERIAL_DATA_LINE_OUT(sda_out), .SERIAL_DATA_LINE_OE(sda_oe),
        .REF_CLK_IN(ref_clk), .GATED_CLOCK_OUTPUTS(gated),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    serial_master_model master (.scl(scl), .pull(m_pull), .sda(sda));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input word_t seen, input word_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input word_t v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output word_t v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask

    // Expected output mask from the three enable bytes
    function automatic logic [12:0] exp_map(byte_t a, byte_t c, byte_t e);
        return {e[6], c[7:4], c[1:0], a[7:6], a[3:0]};
    endfunction

    task automatic chk_regs;
        word_t v;
        reg_read(`OFS_EN0, v); chk(v, {24'h000000, e0});
        reg_read(`OFS_EN1, v); chk(v, {24'h000000, e1});
        reg_read(`OFS_EN2, v); chk(v, {24'h000000, e2});
    endtask

    // Hold the reference high then low and look at all outputs
    task automatic chk_out;
        @(posedge sys_clk) ref_clk <= 1'b1;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({19'h0, gated}, {19'h0, exp_map(e0, e1, e2)});
        @(posedge sys_clk) ref_clk <= 1'b0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({19'h0, gated}, 32'h00000000);
    endtask

    task automatic rnd_frame;
        r = {$random(seed), $random(seed), $random(seed)};
        b = r[79:0];
        b[79:72] = `DEV_ADDR;
    endtask

    task automatic run(input int n);
        master.frame(b, n, acks);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic take_data;
        e0 = b[55:48] & `EN0_MASK;
        e1 = b[47:40] & `EN1_MASK;
        e2 = b[39:32] & `EN2_MASK;
    endtask

    // Seven frames of under 8 us each plus register traffic
    initial begin
        #400000;
        n_errors++;
        give_verdict;
    end

    initial begin
        seed = 32'h400E9B88;
        n_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        ref_clk = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        e0 = `EN0_RST;
        e1 = `EN1_RST;
        e2 = `EN2_RST;
        // Two edges in reset clear both synchroniser stages
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk_regs;
        chk_out;
        // Software path: random enables, reserved bits dropped
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            reg_write(8'(4 * i), d);
            if (i == 0) e0 = d[7:0] & `EN0_MASK;
            if (i == 1) e1 = d[7:0] & `EN1_MASK;
            if (i == 2) e2 = d[7:0] & `EN2_MASK;
        end
        reg_write(8'h3C, 32'hFFFFFFFF);
        reg_read(8'h3C, d);
        chk(d, 32'h00000000);
        chk_regs;
        chk_out;
        // every frame carries the two ignored bytes
        for (int f = 0; f < 4; f++) begin
            rnd_frame;
            if (f == 0) b[55:32] = 24'h000000;
            if (f == 1) b[55:32] = 24'hFFFFFF;
            run(10);
            chk({22'h0, acks}, 32'h000003FF);
            take_data;
            chk_regs;
            chk_out;
        end
        // Status after a full frame: idle, deselected, last position
        reg_read(`OFS_STATUS, d);
        chk(d, 32'h00000090);
        // Serial writes locked: bytes still acked, enables kept
        reg_write(`OFS_CTRL, 32'h00000000);
        reg_read(`OFS_CTRL, d);
        chk(d, 32'h00000000);
        rnd_frame;
        run(10);
        chk({22'h0, acks}, 32'h000003FF);
        chk_regs;
        reg_write(`OFS_CTRL, 32'h00000001);
        reg_read(`OFS_CTRL, d);
        chk(d, 32'h00000001);
        // Foreign address: no answer, nothing stored
        rnd_frame;
        b[79:72] = `DEV_ADDR ^ (8'h01 << r[2:0]);
        run(10);
        chk({22'h0, acks}, 32'h00000000);
        chk_regs;
        // Early stop right after the first data byte
        rnd_frame;
        run(4);
        chk({22'h0, acks}, 32'h0000000F);
        e0 = b[55:48] & `EN0_MASK;
        chk_regs;
        chk_out;
        // Frames that stored data: four full, one cut short
        reg_read(`OFS_COUNT, d);
        chk(d, 32'h00000005);
        give_verdict;
    end
endmodule
